// >>> hw/hccs_top.sv
`timescale 1ns/1ps
// Functional notes
// - Overflow flag on more than 32 writes
// - Overflow cleared by tx reset or half moved
// - Write-ok bit shows transmit FIFO room
// - Auto mode: local receiver not-ready status
// - Auto mode: remote receiver not-ready status
// - Line idle when no flags or frames
// - Busy bit while command executes; wait
// - Busy at most 2.5 tx clocks, except power-down
// - Status mirrors clear-to-send, active low pin
// - Auto mode: waiting for I-frame acknowledgement
// - Receive complete frees receive FIFO space
// - DMA: requests blocked until receive complete or receiver reset
// - Receiver reset discards receive data
// - Auto mode: receiver reset clears sequence counters
// - Auto mode: not-ready bit picks RR/RNR
// - Value 2a starts cyclic transparent repeat
// - Only tx reset stops cyclic repeat
// - Tx reset clears FIFO, aborts, pool-ready
// - Message end appends CRC, closing flag; command ignored in DMA mode
module hccs_top (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Datapath status inputs
    input wire logic i_txclk_en,
    input wire logic i_tx_half_moved,
    input wire logic i_rx_bit_en,
    input wire logic i_rx_activity,
    input wire logic i_rx_msg_end,
    input wire logic i_remote_rr,
    input wire logic i_remote_rnr,
    input wire logic i_ack_rcvd,
    input wire logic i_cts_n,
    // Transmit FIFO write path
    output logic o_tx_fifo_wr,
    output logic [7:0] o_tx_fifo_data,
    // Command pulses
    output logic o_rx_release,
    output logic o_rx_reset,
    output logic o_seq_clear,
    output logic o_timer_start,
    output logic o_send_transp,
    output logic o_send_iframe,
    output logic o_msg_end,
    output logic o_tx_reset,
    output logic o_tx_pool_ready,
    // Levels to the datapath
    output logic o_send_rnr,
    output logic o_tx_repeat,
    output logic o_rx_dma_enable
);
    import hccs_pkg::*;

    hccs_cmd_if cif ();

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [3:0] config_r;
    logic [5:0] tx_cnt_r;
    logic tx_ovf_r;
    logic local_nrdy_r;
    logic remote_nrdy_r;
    logic await_ack_r;
    logic cts_r;
    logic repeat_r;
    logic dma_en_r;
    logic [7:0] rdata_r;
    logic fifo_wr_r;
    logic [7:0] fifo_data_r;
    logic rx_release_r;
    logic rx_reset_r;
    logic seq_clear_r;
    logic timer_start_r;
    logic send_transp_r;
    logic send_iframe_r;
    logic msg_end_r;
    logic tx_reset_r;
    logic pool_ready_r;
    logic rx_idle;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire sel_cmd = i_wr && (i_addr == CHAN_COMMAND_ADDR);
    wire sel_cfg_wr = i_wr && (i_addr == CHAN_CONFIG_ADDR);
    wire sel_fifo = i_wr && (i_addr >= TX_FIFO_ADDR_LO) && (i_addr <= TX_FIFO_ADDR_HI);
    wire rd_status = i_rd && (i_addr == CHAN_STATUS_ADDR);
    wire rd_config = i_rd && (i_addr == CHAN_CONFIG_ADDR);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire auto_mode = config_r[CF_AUTO_MODE];
    wire ext_transp = config_r[CF_EXT_TRANSP];
    wire dma_mode = config_r[CF_DMA_MODE];
    wire power_down = config_r[CF_POWER_DOWN];

    // ------------------------------------------------------------
    // Command executor hookup
    // ------------------------------------------------------------
    assign cif.cmd = i_wdata;
    assign cif.cmd_valid = sel_cmd && !cif.busy;
    assign cif.txclk_en = i_txclk_en;
    assign cif.power_down = power_down;

    hccs_cmd_exec u_exec (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .cif(cif.exec)
    );

    hccs_idle_det u_idle (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_bit_en(i_rx_bit_en),
        .i_activity(i_rx_activity),
        .o_idle(rx_idle)
    );

    // ------------------------------------------------------------
    // Executed command decode, each bit a one-shot
    // ------------------------------------------------------------
    wire [7:0] xcmd = cif.cmd_out;
    wire ex = cif.done;
    wire ex_rx_complete = ex && xcmd[CM_RX_COMPLETE];
    wire ex_rx_reset = ex && xcmd[CM_RX_RESET];
    wire ex_timer = ex && xcmd[CM_TIMER_START];
    wire ex_transp = ex && xcmd[CM_SEND_TRANSP];
    wire ex_iframe = ex && xcmd[CM_SEND_IFRAME] && auto_mode;
    wire ex_msg_end = ex && xcmd[CM_MSG_END] && !dma_mode;
    wire ex_tx_reset = ex && xcmd[CM_TX_RESET];
    wire ex_repeat = ex && ext_transp && (xcmd == CMD_REPEAT_VALUE);
    wire ex_nrdy_set = ex && auto_mode;

    // ------------------------------------------------------------
    // Status composition
    // ------------------------------------------------------------
    wire tx_write_ok = (tx_cnt_r < TX_HALF_BYTES) && !repeat_r;
    wire [7:0] status_word = {tx_ovf_r, tx_write_ok, local_nrdy_r, remote_nrdy_r,
                              rx_idle, cif.busy, cts_r, await_ack_r};
    wire [7:0] rdata_nxt = rd_status ? status_word :
                           rd_config ? {4'h0, config_r} : 8'h00;

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe; no side effects
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            config_r <= CHAN_CONFIG_RST;
        end else if (sel_cfg_wr) begin
            config_r <= i_wdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // Transmit FIFO fill count and overflow flag
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_cnt_r <= 6'h00;
            tx_ovf_r <= 1'b0;
        end else begin
            if (ex_tx_reset || i_tx_half_moved) begin
                tx_cnt_r <= 6'h00;
            end else if (sel_fifo && tx_cnt_r < TX_HALF_BYTES) begin
                tx_cnt_r <= tx_cnt_r + 6'h01;
            end
            if (sel_fifo && tx_cnt_r == TX_HALF_BYTES) begin
                tx_ovf_r <= 1'b1;
            end else if (ex_tx_reset || i_tx_half_moved) begin
                tx_ovf_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit FIFO write forwarding
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fifo_wr_r <= 1'b0;
            fifo_data_r <= 8'h00;
        end else begin
            fifo_wr_r <= sel_fifo && tx_cnt_r < TX_HALF_BYTES;
            fifo_data_r <= sel_fifo ? i_wdata : fifo_data_r;
        end
    end

    // ------------------------------------------------------------
    // Auto mode link state
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            local_nrdy_r <= 1'b0;
            remote_nrdy_r <= 1'b0;
            await_ack_r <= 1'b0;
        end else begin
            if (ex_nrdy_set) begin
                local_nrdy_r <= xcmd[CM_NRDY_REPEAT];
            end
            if (i_remote_rnr) begin
                remote_nrdy_r <= 1'b1;
            end else if (i_remote_rr) begin
                remote_nrdy_r <= 1'b0;
            end
            if (ex_iframe) begin
                await_ack_r <= 1'b1;
            end else if (i_ack_rcvd || ex_tx_reset || (ex_rx_reset && auto_mode)) begin
                await_ack_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Clear-to-send mirror, pin is active low
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cts_r <= 1'b0;
        end else begin
            cts_r <= ~i_cts_n;
        end
    end

    // ------------------------------------------------------------
    // Cyclic transparent repeat
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            repeat_r <= 1'b0;
        end else if (ex_tx_reset) begin
            repeat_r <= 1'b0;
        end else if (ex_repeat) begin
            repeat_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Receive DMA gate; a message end in the completing cycle wins
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dma_en_r <= 1'b1;
        end else if (i_rx_msg_end && dma_mode) begin
            dma_en_r <= 1'b0;
        end else if (ex_rx_complete || ex_rx_reset) begin
            dma_en_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Command pulses to the datapath
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_release_r <= 1'b0;
            rx_reset_r <= 1'b0;
            seq_clear_r <= 1'b0;
            timer_start_r <= 1'b0;
            send_transp_r <= 1'b0;
            send_iframe_r <= 1'b0;
            msg_end_r <= 1'b0;
            tx_reset_r <= 1'b0;
            pool_ready_r <= 1'b0;
        end else begin
            rx_release_r <= ex_rx_complete;
            rx_reset_r <= ex_rx_reset;
            seq_clear_r <= ex_rx_reset && auto_mode;
            timer_start_r <= ex_timer;
            send_transp_r <= ex_transp;
            send_iframe_r <= ex_iframe;
            msg_end_r <= ex_msg_end;
            tx_reset_r <= ex_tx_reset;
            pool_ready_r <= ex_tx_reset;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata = rdata_r;
    assign o_tx_fifo_wr = fifo_wr_r;
    assign o_tx_fifo_data = fifo_data_r;
    assign o_rx_release = rx_release_r;
    assign o_rx_reset = rx_reset_r;
    assign o_seq_clear = seq_clear_r;
    assign o_timer_start = timer_start_r;
    assign o_send_transp = send_transp_r;
    assign o_send_iframe = send_iframe_r;
    assign o_msg_end = msg_end_r;
    assign o_tx_reset = tx_reset_r;
    assign o_tx_pool_ready = pool_ready_r;
    assign o_send_rnr = local_nrdy_r;
    assign o_tx_repeat = repeat_r;
    assign o_rx_dma_enable = dma_en_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_overflow_write;
        sel_fifo && tx_cnt_r == TX_HALF_BYTES;
    endsequence

    sequence s_tx_reset_done;
        ex_tx_reset;
    endsequence

    a_ovf_on_extra: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_overflow_write |=> tx_ovf_r)
        else $error("overflow not flagged");
    a_ovf_cleared: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (ex_tx_reset || i_tx_half_moved) && !(sel_fifo && tx_cnt_r == TX_HALF_BYTES) |=> !tx_ovf_r && tx_cnt_r == 6'h00)
        else $error("overflow not cleared");
    a_write_ok_full: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        tx_cnt_r == TX_HALF_BYTES |-> !status_word[ST_TX_WRITE_OK])
        else $error("write ok shown with full half");
    a_cts_mirror: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ##1 cts_r == !$past(i_cts_n))
        else $error("clear to send not mirrored");
    a_repeat_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        repeat_r && !ex_tx_reset |=> repeat_r)
        else $error("repeat stopped without tx reset");
    a_repeat_start: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ex_repeat && !ex_tx_reset |=> repeat_r ##0 !status_word[ST_TX_WRITE_OK])
        else $error("repeat not started");
    a_txres_pulses: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_tx_reset_done |=> o_tx_reset && o_tx_pool_ready ##1 !o_tx_reset)
        else $error("tx reset pulses wrong");
    a_dma_blocked: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_rx_msg_end && dma_mode |=> !o_rx_dma_enable)
        else $error("dma not blocked after message end");
    a_seq_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ex_rx_reset && auto_mode |=> o_seq_clear && o_rx_reset)
        else $error("sequence counters not cleared");
    a_read_no_effect: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        rd_status && !i_tx_half_moved && !ex |=> $stable(tx_ovf_r))
        else $error("status read changed overflow");
endmodule

// >>> include/hccs_pkg.sv
package hccs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CHAN_STATUS_ADDR = 8'h60;
    localparam logic [7:0] CHAN_COMMAND_ADDR = 8'h60;
    localparam logic [7:0] CHAN_CONFIG_ADDR = 8'h80;
    localparam logic [7:0] TX_FIFO_ADDR_LO = 8'h40;
    localparam logic [7:0] TX_FIFO_ADDR_HI = 8'h5f;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CHAN_STATUS_RST = 8'h48;
    localparam logic [7:0] CHAN_COMMAND_RST = 8'h00;
    localparam logic [3:0] CHAN_CONFIG_RST = 4'h0;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int ST_TX_OVERFLOW = 7;
    localparam int ST_TX_WRITE_OK = 6;
    localparam int ST_LOCAL_NRDY = 5;
    localparam int ST_REMOTE_NRDY = 4;
    localparam int ST_RX_IDLE = 3;
    localparam int ST_CMD_BUSY = 2;
    localparam int ST_CTS = 1;
    localparam int ST_AWAIT_ACK = 0;

    // ------------------------------------------------------------
    // Command bit positions and the repeat pattern
    // ------------------------------------------------------------
    localparam int CM_RX_COMPLETE = 7;
    localparam int CM_RX_RESET = 6;
    localparam int CM_NRDY_REPEAT = 5;
    localparam int CM_TIMER_START = 4;
    localparam int CM_SEND_TRANSP = 3;
    localparam int CM_SEND_IFRAME = 2;
    localparam int CM_MSG_END = 1;
    localparam int CM_TX_RESET = 0;
    localparam logic [7:0] CMD_REPEAT_VALUE = 8'h2a;

    // ------------------------------------------------------------
    // Configuration bit positions
    // ------------------------------------------------------------
    localparam int CF_AUTO_MODE = 0;
    localparam int CF_EXT_TRANSP = 1;
    localparam int CF_DMA_MODE = 2;
    localparam int CF_POWER_DOWN = 3;

    // ------------------------------------------------------------
    // Sizes and timing
    // ------------------------------------------------------------
    localparam logic [5:0] TX_HALF_BYTES = 6'h20;
    localparam real CMD_BUSY_MAX_TXCLK = 2.5;
    localparam int CMD_BUSY_TXCLK_EN = int'($floor(CMD_BUSY_MAX_TXCLK));
    localparam logic [1:0] CMD_BUSY_CNT_LAST = 2'(CMD_BUSY_TXCLK_EN - 1);
    localparam logic [4:0] RX_IDLE_BITS = 5'h0f;

    // Command executor states
    typedef enum logic [2:0] {
        HCCS_EX_IDLE = 3'b001,
        HCCS_EX_WAIT = 3'b010,
        HCCS_EX_DONE = 3'b100
    } hccs_ex_state_e;

endpackage

// >>> include/hccs_cmd_if.sv
`timescale 1ns/1ps
interface hccs_cmd_if;
    logic [7:0] cmd;
    logic cmd_valid;
    logic txclk_en;
    logic power_down;
    logic busy;
    logic done;
    logic [7:0] cmd_out;

    // Register side issues, executor times
    modport regs (output cmd, output cmd_valid, output txclk_en, output power_down,
                  input busy, input done, input cmd_out);
    modport exec (input cmd, input cmd_valid, input txclk_en, input power_down,
                  output busy, output done, output cmd_out);
endinterface

// >>> hw/hccs_cmd_exec.sv
`timescale 1ns/1ps
module hccs_cmd_exec (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Command handshake
    hccs_cmd_if.exec cif
);
    import hccs_pkg::*;

    hccs_ex_state_e state_r;
    hccs_ex_state_e state_nxt;
    logic [1:0] cnt_r;
    logic [7:0] cmd_r;
    logic busy_r;
    logic done_r;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    wire tick = cif.txclk_en && !cif.power_down;
    wire last_tick = tick && (cnt_r == CMD_BUSY_CNT_LAST);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            HCCS_EX_IDLE: begin
                if (cif.cmd_valid) begin
                    state_nxt = HCCS_EX_WAIT;
                end
            end
            HCCS_EX_WAIT: begin
                if (last_tick) begin
                    state_nxt = HCCS_EX_DONE;
                end
            end
            HCCS_EX_DONE: begin
                state_nxt = cif.cmd_valid ? HCCS_EX_WAIT : HCCS_EX_IDLE;
            end
            default: state_nxt = HCCS_EX_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Busy window, bounded by transmit clock ticks
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= HCCS_EX_IDLE;
            cnt_r <= 2'h0;
            cmd_r <= CHAN_COMMAND_RST;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            done_r <= (state_nxt == HCCS_EX_DONE);
            busy_r <= (state_nxt == HCCS_EX_WAIT);
            if (cif.cmd_valid && state_r != HCCS_EX_WAIT) begin
                cmd_r <= cif.cmd;
                cnt_r <= 2'h0;
            end else if (tick) begin
                cnt_r <= cnt_r + 2'h1;
            end
        end
    end

    assign cif.busy = busy_r;
    assign cif.done = done_r;
    assign cif.cmd_out = cmd_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_accept;
        cif.cmd_valid && !busy_r;
    endsequence

    a_busy_after_accept: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_accept |=> busy_r)
        else $error("busy not raised after command");
    a_busy_holds_pd: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        busy_r && cif.power_down |=> busy_r)
        else $error("busy dropped in power down");
    a_done_after_ticks: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        busy_r && last_tick |=> done_r && !busy_r)
        else $error("busy longer than allowed ticks");
endmodule

// >>> hw/hccs_idle_det.sv
`timescale 1ns/1ps
module hccs_idle_det (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Receive line activity
    input wire logic i_bit_en,
    input wire logic i_activity,
    // Idle indication
    output logic o_idle
);
    import hccs_pkg::*;

    logic [4:0] cnt_r;
    logic idle_r;

    // ------------------------------------------------------------
    // Count bit periods with no flag or frame seen
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 5'h00;
            idle_r <= 1'b1;
        end else if (i_activity) begin
            cnt_r <= 5'h00;
            idle_r <= 1'b0;
        end else if (i_bit_en && cnt_r != RX_IDLE_BITS) begin
            cnt_r <= cnt_r + 5'h01;
            idle_r <= (cnt_r + 5'h01 == RX_IDLE_BITS);
        end
    end

    assign o_idle = idle_r;

    a_idle_cleared: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_activity |=> !idle_r && cnt_r == 5'h00)
        else $error("line idle not cleared on activity");
endmodule

// >>> test/hccs_remote_station.sv
`timescale 1ns/1ps
// Remote station: RNR on request, late ack sent with RR
module hccs_remote_station (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Device and bench requests
    input wire logic i_iframe,
    input wire logic i_rnr_req,
    // Replies
    output logic o_ack,
    output logic o_rnr,
    output logic o_rr
);
    logic [5:0] cnt_r;
    // Slow acknowledge timer
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 6'h00;
        end else if (i_iframe) begin
            cnt_r <= 6'h28;
        end else if (cnt_r != 6'h00) begin
            cnt_r <= cnt_r - 6'h01;
        end
    end
    // Replies
    assign o_ack = (cnt_r == 6'h01);
    assign o_rr = o_ack;
    assign o_rnr = i_rnr_req;
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import hccs_pkg::*;
    logic i_clk_sys, i_rst_n, i_wr, i_rd, i_cts_n, rnr_req, rd_d, ack, rnr, rr, ifr;
    logic [7:0] i_addr, i_wdata, o_rdata;
    logic [4:0] strb;
    wire [8:0] pv;
    wire [7:0] fd;
    wire [2:0] lv;
    logic [9:0] pulse_seen = '0;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'hbfd5;
    int mismatches = 0;
    int n_tests = 0;

    hccs_top hccs_top_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_txclk_en(strb[0]), .i_tx_half_moved(strb[1]),
        .i_rx_bit_en(strb[2]), .i_rx_activity(strb[3]), .i_rx_msg_end(strb[4]), .i_remote_rr(rr),
        .i_remote_rnr(rnr), .i_ack_rcvd(ack), .i_cts_n(i_cts_n), .o_tx_fifo_wr(pv[8]), .o_tx_fifo_data(fd),
        .o_rx_release(pv[0]), .o_rx_reset(pv[1]), .o_seq_clear(pv[2]), .o_timer_start(pv[3]),
        .o_send_transp(pv[4]), .o_send_iframe(ifr), .o_msg_end(pv[5]), .o_tx_reset(pv[6]),
        .o_tx_pool_ready(pv[7]), .o_send_rnr(lv[0]), .o_tx_repeat(lv[1]), .o_rx_dma_enable(lv[2]));
    hccs_remote_station hccs_remote_station_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_iframe(ifr), .i_rnr_req(rnr_req), .o_ack(ack), .o_rnr(rnr), .o_rr(rr));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Bus cycles and strobes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
    endtask
    task automatic pulse(input int k);
        @(posedge i_clk_sys);
        strb[k] <= 1'b1;
        @(posedge i_clk_sys);
        strb[k] <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] busy_exp);
        wr(CHAN_COMMAND_ADDR, c);
        rd(CHAN_STATUS_ADDR, busy_exp);
        repeat (2) pulse(0);
        repeat (2) @(posedge i_clk_sys);
    endtask
    // Clock
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    // Watchdog
    initial begin
        #(25 * 4000);
        mismatches++;
        tally_and_finish();
    end
    // Read data watcher
    always @(posedge i_clk_sys) rd_d <= i_rd;
    always @(negedge i_clk_sys) begin
        if (rd_d === 1'b1) begin
            check("o_rdata", {2'b00, o_rdata}, {2'b00, exp_q.pop_front()});
        end
    end
    // Sticky record of every command pulse seen
    always @(posedge i_clk_sys) begin
        if (i_rst_n) begin
            pulse_seen <= pulse_seen | {ifr, pv};
        end
    end
    // Main sequence
    initial begin
        {i_rst_n, i_wr, i_rd, rnr_req, i_addr, i_wdata, strb} = '0;
        i_cts_n = 1'b1;
        repeat (5) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        rd(CHAN_STATUS_ADDR, CHAN_STATUS_RST);
        rd(8'h10, 8'h00);
        repeat (33) begin
            seed = xs(seed);
            wr(TX_FIFO_ADDR_LO + {3'b000, seed[4:0]}, seed[15:8]);
        end
        rd(CHAN_STATUS_ADDR, 8'h88);
        rd(CHAN_STATUS_ADDR, 8'h88);
        pulse(1);
        rd(CHAN_STATUS_ADDR, 8'h48);
        wr(TX_FIFO_ADDR_LO, 8'h5a);
        @(posedge i_clk_sys);
        check("o_tx_fifo_data", {2'b00, fd}, 10'h05a);
        i_cts_n <= 1'b0;
        rd(CHAN_STATUS_ADDR, 8'h4a);
        i_cts_n <= 1'b1;
        wr(CHAN_CONFIG_ADDR, 8'h01);
        cmd(8'h20, 8'h4c);
        rd(CHAN_STATUS_ADDR, 8'h68);
        check("levels", {7'h00, lv}, 10'h005);
        @(posedge i_clk_sys);
        rnr_req <= 1'b1;
        @(posedge i_clk_sys);
        rnr_req <= 1'b0;
        rd(CHAN_STATUS_ADDR, 8'h78);
        cmd(8'h04, 8'h7c);
        rd(CHAN_STATUS_ADDR, 8'h59);
        repeat (50) @(posedge i_clk_sys);
        rd(CHAN_STATUS_ADDR, 8'h48);
        pulse(3);
        rd(CHAN_STATUS_ADDR, 8'h40);
        repeat (15) pulse(2);
        rd(CHAN_STATUS_ADDR, 8'h48);
        cmd(8'h01, 8'h4c);
        rd(CHAN_STATUS_ADDR, 8'h48);
        check("pulses", pulse_seen, 10'h3c0);
        wr(CHAN_CONFIG_ADDR, 8'h02);
        cmd(8'h2a, 8'h4c);
        rd(CHAN_STATUS_ADDR, 8'h08);
        check("levels", {7'h00, lv}, 10'h006);
        check("pulses", pulse_seen, 10'h3f0);
        cmd(8'h10, 8'h0c);
        rd(CHAN_STATUS_ADDR, 8'h08);
        cmd(8'h01, 8'h0c);
        rd(CHAN_STATUS_ADDR, 8'h48);
        wr(CHAN_CONFIG_ADDR, 8'h05);
        pulse(4);
        @(posedge i_clk_sys);
        check("levels", {7'h00, lv}, 10'h000);
        cmd(8'hc0, 8'h4c);
        rd(CHAN_STATUS_ADDR, 8'h48);
        check("levels", {7'h00, lv}, 10'h004);
        check("pulses", pulse_seen, 10'h3ff);
        repeat (3) @(posedge i_clk_sys);
        tally_and_finish();
    end
endmodule
